/* File: inc/slc_pkg.sv */
// constants and types for the synthesizer loop control register bank
package slc_pkg;

  localparam int SLC_NUM_REGS = 13;

  // register indices into the storage array
  localparam logic [3:0] SLC_IX_CFG = 4'h0;
  localparam logic [3:0] SLC_IX_XFER = 4'h1;
  localparam logic [3:0] SLC_IX_INT_LO = 4'h2;
  localparam logic [3:0] SLC_IX_INT_HI = 4'h3;
  localparam logic [3:0] SLC_IX_CALPRE = 4'h4;
  localparam logic [3:0] SLC_IX_FRAC_B0 = 4'h5;
  localparam logic [3:0] SLC_IX_FRAC_B1 = 4'h6;
  localparam logic [3:0] SLC_IX_FRAC_B2 = 4'h7;
  localparam logic [3:0] SLC_IX_SHARED = 4'h8;
  localparam logic [3:0] SLC_IX_AUX_HI = 4'h9;
  localparam logic [3:0] SLC_IX_MOD_LO = 4'ha;
  localparam logic [3:0] SLC_IX_MOD_HI = 4'hb;
  localparam logic [3:0] SLC_IX_PUMP = 4'hc;
  localparam logic [3:0] SLC_IX_NONE = 4'hf;

  // serial addresses, reset values and writable bits, in index order
  localparam logic [14:0] SLC_ADDR [SLC_NUM_REGS] = '{
    15'h0000, 15'h0001, 15'h0010, 15'h0011, 15'h0012, 15'h0014, 15'h0015,
    15'h0016, 15'h0017, 15'h0018, 15'h0019, 15'h001a, 15'h001e};
  // the configuration entry holds only its low nibble; the upper half is a mirror
  localparam logic [7:0] SLC_RESET [SLC_NUM_REGS] = '{
    8'h08, 8'h00, 8'h32, 8'h00, 8'h40, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'he8, 8'h03, 8'h48};
  localparam logic [7:0] SLC_WMASK [SLC_NUM_REGS] = '{
    8'h0e, 8'he0, 8'hff, 8'hff, 8'h60, 8'hff, 8'hff,
    8'hff, 8'hff, 8'h7f, 8'hff, 8'h3f, 8'hfd};

  // field positions
  localparam int SLC_CFG_SOFT_BIT = 0;
  localparam int SLC_CFG_LSB_FIRST_BIT = 1;
  localparam int SLC_CFG_ASCEND_BIT = 2;
  localparam int SLC_CFG_FOUR_PIN_BIT = 3;
  localparam int SLC_CFG_SOFT_MIRROR_BIT = 7;
  localparam int SLC_XFER_SINGLE_BIT = 7;
  localparam int SLC_CAL_ENABLE_BIT = 6;
  localparam int SLC_PRESCALER_BIT = 5;
  localparam int SLC_PUMP_MSB = 7;
  localparam int SLC_PUMP_LSB = 4;
  localparam int SLC_SIGN_BIT = 3;
  localparam int SLC_POWERDOWN_BIT = 2;
  localparam int SLC_HOLD_BIT = 0;

  // serial frame counts
  localparam logic [3:0] SLC_INSTR_LAST = 4'hf;
  localparam logic [3:0] SLC_BYTE_LAST = 4'h7;
  localparam logic [2:0] SLC_BIT_TOP = 3'h7;
  localparam int SLC_RW_BIT = 15;

  // system clock cycles the link-side clear is held after a soft reset
  localparam logic [2:0] SLC_CLEAR_CYCLES = 3'h4;

  // pump current step in microamps
  localparam logic [12:0] SLC_PUMP_STEP_UA = 13'h015e;

  typedef enum logic [1:0] {
    SLC_ST_INSTR = 2'b00,
    SLC_ST_DATA = 2'b01,
    SLC_ST_DONE = 2'b11
  } slc_state_t;

  typedef struct packed {
    logic [15:0] integer_word;
    logic [24:0] primary_fraction;
    logic [13:0] aux_fraction;
    logic [13:0] aux_modulus;
  } slc_divider_t;

  typedef struct packed {
    logic band_calibration_enable;
    logic prescaler_eight_nine;
    logic [3:0] pump_current_code;
    logic detector_sign_select;
    logic loop_mode_powerdown;
    logic divider_hold;
    logic four_pin_select;
  } slc_control_t;

  localparam slc_divider_t SLC_DIVIDER_RESET = '{16'h0032, 25'h0000000, 14'h0000, 14'h03e8};
  localparam slc_control_t SLC_CONTROL_RESET = '{1'b1, 1'b0, 4'h4, 1'b1, 1'b0, 1'b0, 1'b1};

endpackage : slc_pkg

/* File: logic/slc_register_bank.sv */
// serial-port register bank of the translation-loop synthesizer control block
`timescale 1ns/1ps
`default_nettype none

module slc_register_bank
  import slc_pkg::*;
(
  // system side
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // serial link
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_SELECT_N,
  input wire logic SDIO_IN,
  output logic SDIO_OUT,
  output logic SDIO_DRIVE_N,
  output logic MULTIPLEXED_OUTPUT_PIN,
  // multiplexed output function
  input wire logic MULTIPLEXED_FUNCTION_ENABLE,
  input wire logic MULTIPLEXED_FUNCTION_SIGNAL,
  // synthesizer controls
  output slc_divider_t DIVIDER_WORDS,
  output logic DIVIDER_LOAD,
  output slc_control_t LOOP_CONTROL,
  output logic [12:0] PUMP_CURRENT_UA,
  output logic PLL_BLOCKS_ON,
  output logic FEEDBACK_DIVIDER_RESET,
  output logic REFERENCE_COUNTER_RESET
);

  function automatic logic [3:0] slc_index(input logic [14:0] addr);
    logic [3:0] idx;
    idx = SLC_IX_NONE;
    for (int i = 0; i < SLC_NUM_REGS; i++)
    begin
      if (addr == SLC_ADDR[i])
        idx = 4'(i);
    end
    return idx;
  endfunction : slc_index

  function automatic logic [7:0] slc_rev8(input logic [7:0] value);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = value[7 - i];
    return r;
  endfunction : slc_rev8

  // a toggle counts once the second and third stages agree and differ from the last one taken
  function automatic logic slc_event(input logic [2:0] sync, input logic taken);
    return (sync[1] == sync[2]) && (sync[2] != taken);
  endfunction : slc_event

  // ---------------- link domain ----------------
  logic [7:0] regs [SLC_NUM_REGS];
  logic link_clear;
  logic frame_rst;
  slc_state_t state;
  slc_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [14:0] shift_in;
  logic [14:0] cur_addr;
  logic [14:0] next_addr;
  logic [14:0] step_addr;
  logic read_op;
  logic next_read_op;
  logic four_pin;
  logic ascend;
  logic lsb_first;
  logic single_access;
  logic [15:0] instr_word;
  logic [15:0] instr_ord;
  logic [7:0] byte_word;
  logic [7:0] byte_ord;
  logic instr_last;
  logic byte_last;
  logic [3:0] acc_index;
  logic write_now;
  logic soft_hit;
  logic [7:0] wr_mask;
  logic [7:0] wr_fold;
  logic [7:0] write_value;
  logic [7:0] cfg_view;
  logic [7:0] rd_byte;
  logic [2:0] bit_sel;
  logic sdo_bit;
  logic sdo_drive;
  logic upd_tog;
  logic load_tog;
  logic soft_tog;

  // the frame ends on deselect; a soft clear also ends the frame in progress
  assign frame_rst = SERIAL_SELECT_N | link_clear;

  assign four_pin = regs[SLC_IX_CFG][SLC_CFG_FOUR_PIN_BIT];
  assign ascend = regs[SLC_IX_CFG][SLC_CFG_ASCEND_BIT];
  assign lsb_first = regs[SLC_IX_CFG][SLC_CFG_LSB_FIRST_BIT];
  assign single_access = regs[SLC_IX_XFER][SLC_XFER_SINGLE_BIT];

  assign instr_word = {shift_in, SDIO_IN};
  assign instr_ord = lsb_first ? {slc_rev8(instr_word[7:0]), slc_rev8(instr_word[15:8])}
                               : instr_word;
  assign byte_word = {shift_in[6:0], SDIO_IN};
  assign byte_ord = lsb_first ? slc_rev8(byte_word) : byte_word;

  assign instr_last = (state == SLC_ST_INSTR) && (bit_cnt == SLC_INSTR_LAST);
  assign byte_last = (state == SLC_ST_DATA) && (bit_cnt == SLC_BYTE_LAST);
  assign step_addr = ascend ? cur_addr + 15'h0001 : cur_addr - 15'h0001;

  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt + 4'h1;
    next_addr = cur_addr;
    next_read_op = read_op;
    case (state)
      SLC_ST_INSTR:
      begin
        if (instr_last)
        begin
          next_state = SLC_ST_DATA;
          next_bit_cnt = 4'h0;
          next_addr = instr_ord[14:0];
          next_read_op = instr_ord[SLC_RW_BIT];
        end
      end
      SLC_ST_DATA:
      begin
        if (byte_last)
        begin
          next_bit_cnt = 4'h0;
          next_addr = step_addr;
          if (single_access)
            next_state = SLC_ST_DONE;
        end
      end
      SLC_ST_DONE:
        next_bit_cnt = bit_cnt;
      default:
        next_state = SLC_ST_DONE;
    endcase
  end

  always_ff @(posedge SERIAL_CLK or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      state <= SLC_ST_INSTR;
      bit_cnt <= 4'h0;
      shift_in <= 15'h0000;
      cur_addr <= 15'h0000;
      read_op <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift_in <= instr_word[14:0];
      cur_addr <= next_addr;
      read_op <= next_read_op;
    end
  end

  // register write path
  assign acc_index = slc_index(cur_addr);
  assign write_now = byte_last && !read_op && (acc_index != SLC_IX_NONE);
  assign soft_hit = (acc_index == SLC_IX_CFG) &&
                    (byte_ord[SLC_CFG_SOFT_BIT] | byte_ord[SLC_CFG_SOFT_MIRROR_BIT]);
  // a one in either copy sets the configuration bit
  assign wr_fold = {4'h0, byte_ord[4], byte_ord[5], byte_ord[6], byte_ord[7]};
  assign wr_mask = (acc_index == SLC_IX_NONE) ? 8'h00 : SLC_WMASK[acc_index];
  assign write_value = ((acc_index == SLC_IX_CFG) ? (byte_ord | wr_fold) : byte_ord)
                       & wr_mask;

  always_ff @(posedge SERIAL_CLK or posedge link_clear)
  begin
    if (link_clear)
    begin
      for (int i = 0; i < SLC_NUM_REGS; i++)
        regs[i] <= SLC_RESET[i];
      upd_tog <= 1'b0;
      load_tog <= 1'b0;
      soft_tog <= 1'b0;
    end
    else if (write_now)
    begin
      if (soft_hit)
        soft_tog <= ~soft_tog;
      else
      begin
        regs[acc_index] <= write_value;
        upd_tog <= ~upd_tog;
        if (acc_index == SLC_IX_INT_LO)
          load_tog <= ~load_tog;
      end
    end
  end

  // read path; soft reset bits are never stored, so they read 0
  assign cfg_view = {regs[SLC_IX_CFG][0], regs[SLC_IX_CFG][1], regs[SLC_IX_CFG][2],
                     regs[SLC_IX_CFG][3], regs[SLC_IX_CFG][3:0]};
  assign rd_byte = (acc_index == SLC_IX_NONE) ? 8'h00 :
                   (acc_index == SLC_IX_CFG) ? cfg_view : regs[acc_index];
  assign bit_sel = lsb_first ? bit_cnt[2:0] : SLC_BIT_TOP - bit_cnt[2:0];

  // read data changes on the falling edge so the host samples it on the rising edge
  always_ff @(negedge SERIAL_CLK or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      sdo_bit <= 1'b0;
      sdo_drive <= 1'b0;
    end
    else
    begin
      sdo_bit <= (state == SLC_ST_DATA) && read_op && rd_byte[bit_sel];
      sdo_drive <= (state == SLC_ST_DATA) && read_op && !four_pin;
    end
  end

  assign SDIO_OUT = sdo_bit;
  assign SDIO_DRIVE_N = ~sdo_drive | SERIAL_SELECT_N;

  // ---------------- system domain ----------------
  logic [2:0] upd_sync;
  logic [2:0] load_sync;
  logic [2:0] soft_sync;
  logic [2:0] mux_en_sync;
  logic [2:0] mux_sig_sync;
  logic upd_taken;
  logic load_taken;
  logic soft_taken;
  logic upd_fire;
  logic load_fire;
  logic soft_fire;
  logic mux_en;
  logic mux_sig;
  logic [2:0] clear_cnt;
  logic [2:0] next_clear_cnt;
  logic sys_clear;
  slc_divider_t live_div;
  slc_control_t live_ctl;
  logic [12:0] live_ua;

  assign upd_fire = slc_event(upd_sync, upd_taken);
  assign load_fire = slc_event(load_sync, load_taken);
  assign soft_fire = slc_event(soft_sync, soft_taken);
  assign sys_clear = !RST_N || link_clear;

  assign next_clear_cnt = (!RST_N || soft_fire) ? SLC_CLEAR_CYCLES :
                          (clear_cnt != 3'h0) ? clear_cnt - 3'h1 : 3'h0;

  always_ff @(posedge SYS_CLK)
  begin
    clear_cnt <= next_clear_cnt;
    link_clear <= !RST_N || (next_clear_cnt != 3'h0);
  end

  // link registers only move one byte time after a toggle, so they are stable when sampled
  assign live_div.integer_word = {regs[SLC_IX_INT_HI], regs[SLC_IX_INT_LO]};
  assign live_div.primary_fraction = {regs[SLC_IX_SHARED][0], regs[SLC_IX_FRAC_B2],
                                      regs[SLC_IX_FRAC_B1], regs[SLC_IX_FRAC_B0]};
  assign live_div.aux_fraction = {regs[SLC_IX_AUX_HI][6:0], regs[SLC_IX_SHARED][7:1]};
  assign live_div.aux_modulus = {regs[SLC_IX_MOD_HI][5:0], regs[SLC_IX_MOD_LO]};
  assign live_ctl.band_calibration_enable = regs[SLC_IX_CALPRE][SLC_CAL_ENABLE_BIT];
  assign live_ctl.prescaler_eight_nine = regs[SLC_IX_CALPRE][SLC_PRESCALER_BIT];
  assign live_ctl.pump_current_code = regs[SLC_IX_PUMP][SLC_PUMP_MSB:SLC_PUMP_LSB];
  assign live_ctl.detector_sign_select = regs[SLC_IX_PUMP][SLC_SIGN_BIT];
  assign live_ctl.loop_mode_powerdown = regs[SLC_IX_PUMP][SLC_POWERDOWN_BIT];
  assign live_ctl.divider_hold = regs[SLC_IX_PUMP][SLC_HOLD_BIT];
  assign live_ctl.four_pin_select = four_pin;
  assign live_ua = SLC_PUMP_STEP_UA * ({9'h000, live_ctl.pump_current_code} + 13'h0001);

  always_ff @(posedge SYS_CLK)
  begin
    if (sys_clear)
    begin
      upd_sync <= 3'h0;
      load_sync <= 3'h0;
      soft_sync <= 3'h0;
      upd_taken <= 1'b0;
      load_taken <= 1'b0;
      soft_taken <= 1'b0;
    end
    else
    begin
      upd_sync <= {upd_sync[1:0], upd_tog};
      load_sync <= {load_sync[1:0], load_tog};
      soft_sync <= {soft_sync[1:0], soft_tog};
      upd_taken <= (upd_sync[1] == upd_sync[2]) ? upd_sync[2] : upd_taken;
      load_taken <= (load_sync[1] == load_sync[2]) ? load_sync[2] : load_taken;
      soft_taken <= (soft_sync[1] == soft_sync[2]) ? soft_sync[2] : soft_taken;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (sys_clear)
    begin
      LOOP_CONTROL <= SLC_CONTROL_RESET;
      PUMP_CURRENT_UA <= SLC_PUMP_STEP_UA * 13'h0005;
    end
    else if (upd_fire)
    begin
      LOOP_CONTROL <= live_ctl;
      PUMP_CURRENT_UA <= live_ua;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (sys_clear)
    begin
      DIVIDER_WORDS <= SLC_DIVIDER_RESET;
      DIVIDER_LOAD <= 1'b0;
    end
    else
    begin
      DIVIDER_WORDS <= load_fire ? live_div : DIVIDER_WORDS;
      DIVIDER_LOAD <= load_fire;
    end
  end

  // mux function pins are straps from outside, filtered through three stages
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      mux_en_sync <= 3'h0;
      mux_sig_sync <= 3'h0;
      mux_en <= 1'b0;
      mux_sig <= 1'b0;
    end
    else
    begin
      mux_en_sync <= {mux_en_sync[1:0], MULTIPLEXED_FUNCTION_ENABLE};
      mux_sig_sync <= {mux_sig_sync[1:0], MULTIPLEXED_FUNCTION_SIGNAL};
      mux_en <= (mux_en_sync[1] == mux_en_sync[2]) ? mux_en_sync[2] : mux_en;
      mux_sig <= (mux_sig_sync[1] == mux_sig_sync[2]) ? mux_sig_sync[2] : mux_sig;
    end
  end

  assign MULTIPLEXED_OUTPUT_PIN = mux_en ? mux_sig : sdo_bit;
  assign PLL_BLOCKS_ON = ~LOOP_CONTROL.loop_mode_powerdown;
  assign FEEDBACK_DIVIDER_RESET = LOOP_CONTROL.divider_hold;
  assign REFERENCE_COUNTER_RESET = LOOP_CONTROL.divider_hold;

endmodule : slc_register_bank

`default_nettype wire

/* File: tb/slc_bank_monitor.sv */
// checker for pin, control and divider behaviour of the register bank
`timescale 1ns/1ps
`default_nettype none
module slc_bank_monitor
  import slc_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // serial pins
  input wire logic SERIAL_SELECT_N,
  input wire logic SDIO_OUT,
  input wire logic SDIO_DRIVE_N,
  input wire logic MULTIPLEXED_OUTPUT_PIN,
  input wire logic MULTIPLEXED_FUNCTION_ENABLE,
  // synthesizer controls
  input wire slc_divider_t DIVIDER_WORDS,
  input wire logic DIVIDER_LOAD,
  input wire slc_control_t LOOP_CONTROL,
  input wire logic [12:0] PUMP_CURRENT_UA,
  input wire logic PLL_BLOCKS_ON,
  input wire logic FEEDBACK_DIVIDER_RESET,
  input wire logic REFERENCE_COUNTER_RESET
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // three sync stages plus the agreeing stage: five low samples before the pin is read data
  sequence s_mux_off; !MULTIPLEXED_FUNCTION_ENABLE [*5]; endsequence
  sequence s_ctl_steady; $stable(LOOP_CONTROL) [*2]; endsequence
  sequence s_load_once; DIVIDER_LOAD ##1 !DIVIDER_LOAD; endsequence
  property p_quiet_four_pin; LOOP_CONTROL.four_pin_select |-> SDIO_DRIVE_N; endproperty
  property p_drive_framed; !SDIO_DRIVE_N |-> !SERIAL_SELECT_N; endproperty
  property p_mux_read_data; s_mux_off |-> MULTIPLEXED_OUTPUT_PIN == SDIO_OUT; endproperty
  property p_pump_current;
    s_ctl_steady |->
      PUMP_CURRENT_UA == (13'(LOOP_CONTROL.pump_current_code) + 13'h1) * SLC_PUMP_STEP_UA;
  endproperty
  property p_blocks_on; PLL_BLOCKS_ON != LOOP_CONTROL.loop_mode_powerdown; endproperty
  property p_counter_hold;
    FEEDBACK_DIVIDER_RESET == LOOP_CONTROL.divider_hold &&
      REFERENCE_COUNTER_RESET == LOOP_CONTROL.divider_hold;
  endproperty
  property p_load_single; DIVIDER_LOAD |-> s_load_once; endproperty
  property p_divider_reset;
    $rose(RST_N) |-> DIVIDER_WORDS == SLC_DIVIDER_RESET && !DIVIDER_LOAD;
  endproperty
  property p_control_reset;
    $rose(RST_N) |-> LOOP_CONTROL == SLC_CONTROL_RESET && PUMP_CURRENT_UA == 13'h06d6;
  endproperty
  a_quiet_four_pin: assert property (p_quiet_four_pin)
    else $error("data pin driven in four-pin mode");
  a_drive_framed: assert property (p_drive_framed)
    else $error("data pin driven outside a frame");
  a_mux_read_data: assert property (p_mux_read_data)
    else $error("mux pin differs from read data");
  a_pump_current: assert property (p_pump_current)
    else $error("pump current does not follow code");
  a_blocks_on: assert property (p_blocks_on)
    else $error("loop blocks power wrong");
  a_counter_hold: assert property (p_counter_hold)
    else $error("counter hold outputs wrong");
  a_load_single: assert property (p_load_single)
    else $error("divider load longer than one cycle");
  a_divider_reset: assert property (p_divider_reset)
    else $error("divider words not at reset value");
  a_control_reset: assert property (p_control_reset)
    else $error("loop control not at reset value");
endmodule : slc_bank_monitor
bind slc_register_bank slc_bank_monitor mon_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .SERIAL_SELECT_N(SERIAL_SELECT_N), .SDIO_OUT(SDIO_OUT), .SDIO_DRIVE_N(SDIO_DRIVE_N),
  .MULTIPLEXED_OUTPUT_PIN(MULTIPLEXED_OUTPUT_PIN),
  .MULTIPLEXED_FUNCTION_ENABLE(MULTIPLEXED_FUNCTION_ENABLE), .DIVIDER_WORDS(DIVIDER_WORDS),
  .DIVIDER_LOAD(DIVIDER_LOAD), .LOOP_CONTROL(LOOP_CONTROL), .PUMP_CURRENT_UA(PUMP_CURRENT_UA),
  .PLL_BLOCKS_ON(PLL_BLOCKS_ON), .FEEDBACK_DIVIDER_RESET(FEEDBACK_DIVIDER_RESET),
  .REFERENCE_COUNTER_RESET(REFERENCE_COUNTER_RESET));
`default_nettype wire

/* File: tb/slc_host_model.sv */
// host controller model that drives serial frames into the register bank
`timescale 1ns/1ps
`default_nettype none
module slc_host_model (
  // serial link
  output logic sclk,
  output logic sel_n,
  output logic sdio_in,
  // device pins
  input wire logic sdio_out,
  input wire logic sdio_drive_n,
  input wire logic mux_pin
);
  logic bit_o = 1'b0;
  logic oe_h = 1'b1;
  initial
  begin
    sclk = 1'b0;
    sel_n = 1'b1;
  end
  // a released line shows the inverse of the last bit, so a stale copy never passes
  assign sdio_in = !sdio_drive_n ? sdio_out : (oe_h ? bit_o : !bit_o);
  // clock stands low between frames
  task automatic xfer(input logic rd, input logic [14:0] a, input int nb,
    input logic [15:0] wd, input logic lsb, input logic three,
    output logic [15:0] rv, output logic drv);
    logic [15:0] ins;
    int j;
    int p;
    ins = {rd, a};
    rv = '0;
    drv = rd;
    #1.3 sel_n = 1'b0;
    for (int i = 0; i < 16 + 8 * nb; i++)
    begin
      j = i - 16;
      p = 8 * (nb - 1 - j / 8) + (lsb ? j % 8 : 7 - j % 8);
      oe_h = !(rd && i > 15);
      bit_o = (i < 16) ? (lsb ? ins[i] : ins[15 - i]) : wd[p];
      #62.5 sclk = 1'b1;
      if (rd && i > 15)
      begin
        rv[p] = three ? sdio_in : mux_pin;
        drv = drv & !sdio_drive_n;
      end
      #62.5 sclk = 1'b0;
    end
    #62.5 sel_n = 1'b1;
    #125;
  endtask : xfer
endmodule : slc_host_model
`default_nettype wire

/* File: tb/synth_loop_control_registers_tb_top.sv */
// self-checking bench for the synthesizer loop control register bank
`timescale 1ns/1ps
`default_nettype none
module synth_loop_control_registers_tb_top
  import slc_pkg::*;
();
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mux_en = 1'b0;
  logic mux_sig = 1'b0;
  logic sclk, sel_n, sdio_in, sdio_out, sdio_drive_n, mux_pin, div_load, pll_on, fb_rst, ref_rst;
  slc_divider_t div_words;
  slc_control_t loop_ctl;
  logic [12:0] pump_ua;
  logic [7:0] sh [SLC_NUM_REGS];
  logic [3:0] cfg;
  logic [68:0] dexp;
  logic lsb = 1'b0;
  logic three = 1'b0;
  logic [15:0] rv;
  logic [15:0] v;
  logic drv;
  int n_fail = 0;
  int checks = 0;
  int n_load = 0;
  int seed = 13;
  int k;
  always #2.5 sys_clk = !sys_clk;
  always @(posedge sys_clk) if (div_load === 1'b1) n_load <= n_load + 1;
  slc_register_bank dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .SERIAL_CLK(sclk),
    .SERIAL_SELECT_N(sel_n), .SDIO_IN(sdio_in), .SDIO_OUT(sdio_out),
    .SDIO_DRIVE_N(sdio_drive_n), .MULTIPLEXED_OUTPUT_PIN(mux_pin),
    .MULTIPLEXED_FUNCTION_ENABLE(mux_en), .MULTIPLEXED_FUNCTION_SIGNAL(mux_sig),
    .DIVIDER_WORDS(div_words), .DIVIDER_LOAD(div_load), .LOOP_CONTROL(loop_ctl),
    .PUMP_CURRENT_UA(pump_ua), .PLL_BLOCKS_ON(pll_on), .FEEDBACK_DIVIDER_RESET(fb_rst),
    .REFERENCE_COUNTER_RESET(ref_rst));
  slc_host_model host_u (.sclk(sclk), .sel_n(sel_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_drive_n(sdio_drive_n), .mux_pin(mux_pin));
  function automatic logic [68:0] exp_div();
    return {sh[3], sh[2], sh[8][0], sh[7], sh[6], sh[5], sh[9][6:0], sh[8][7:1], sh[11][5:0],
      sh[10]};
  endfunction : exp_div
  function automatic logic [9:0] exp_ctl();
    return {sh[4][6], sh[4][5], sh[12][7:4], sh[12][3], sh[12][2], sh[12][0], cfg[3]};
  endfunction : exp_ctl
  task automatic check(input string what, input logic [68:0] seen, input logic [68:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [14:0] a, input int nb, input logic [15:0] d);
    host_u.xfer(1'b0, a, nb, d, lsb, three, rv, drv);
  endtask : wr
  task automatic rd(input logic [14:0] a, input int nb, input logic [15:0] e);
    host_u.xfer(1'b1, a, nb, 16'h0000, lsb, three, rv, drv);
    check("read data", rv, e);
    check("pin drive", drv, three);
  endtask : rd
  task automatic rst_sh();
    for (int i = 0; i < SLC_NUM_REGS; i++)
      sh[i] = SLC_RESET[i];
    cfg = 4'h8;
    dexp = exp_div();
  endtask : rst_sh
  task automatic chk_all(input bit full);
    check("loop control", loop_ctl, exp_ctl());
    check("divider words", div_words, dexp);
    check("pump current", pump_ua, (13'(sh[12][7:4]) + 13'h1) * 13'h015e);
    check("blocks on", pll_on, !sh[12][2]);
    check("counter hold", {fb_rst, ref_rst}, {2{sh[12][0]}});
    // bit 7 mirrors bit 0, bit 4 mirrors bit 3
    rd(15'h0000, 1, {cfg[0], cfg[1], cfg[2], cfg[3], cfg});
    for (int i = 1; i < SLC_NUM_REGS && full; i++)
      rd(SLC_ADDR[i], 1, sh[i]);
    if (full)
      rd(15'h0013, 1, 16'h0000);
  endtask : chk_all
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    rst_sh();
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk_all(1);
    $display("test reset values done");
    // 0x10 goes first, so every later divider byte must stay pending
    for (int i = 2; i < SLC_NUM_REGS; i++)
    begin
      v = $random(seed);
      wr(SLC_ADDR[i], 1, v);
      sh[i] = v[7:0] & SLC_WMASK[i];
      if (i == 2)
        dexp = exp_div();
    end
    chk_all(1);
    k = n_load;
    v = $random(seed);
    wr(15'h0011, 2, v);
    sh[3] = v[15:8];
    sh[2] = v[7:0];
    dexp = exp_div();
    chk_all(0);
    check("load pulses", n_load - k, 1);
    $display("test double buffer done");
    for (int i = 0; i < 2; i++)
    begin
      wr(15'h001e, 1, i ? 16'h0000 : 16'h00ff);
      sh[12] = i ? 8'h00 : 8'hfd;
      chk_all(0);
      rd(15'h001e, 1, sh[12]);
    end
    wr(15'h0010, 1, sh[2]);
    $display("test pump corners done");
    wr(15'h0000, 1, 16'h000c);
    cfg = 4'hc;
    v = $random(seed);
    wr(15'h0014, 2, v);
    sh[5] = v[15:8];
    sh[6] = v[7:0];
    rd(15'h0015, 2, {sh[6], sh[7]});
    wr(15'h0001, 1, 16'h0080);
    sh[1] = 8'h80;
    v = ~v;
    wr(15'h0014, 2, v);
    sh[5] = v[15:8];
    rd(15'h0014, 2, {sh[5], 8'h00});
    chk_all(0);
    $display("test stream modes done");
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    rst_sh();
    chk_all(1);
    $display("test second reset done");
    wr(15'h0000, 1, 16'h000a);
    cfg = 4'ha;
    lsb = 1'b1;
    rd(15'h001a, 2, {sh[11], sh[10]});
    chk_all(0);
    wr(15'h0000, 1, 16'h0001);
    lsb = 1'b0;
    repeat (20) @(negedge sys_clk);
    rst_sh();
    chk_all(1);
    $display("test low bit first done");
    wr(15'h0000, 1, 16'h0000);
    cfg = 4'h0;
    three = 1'b1;
    chk_all(0);
    wr(15'h0000, 1, 16'h0080);
    three = 1'b0;
    repeat (20) @(negedge sys_clk);
    rst_sh();
    chk_all(0);
    $display("test three pin done");
    @(negedge sys_clk);
    mux_en = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      mux_sig = v[0];
      repeat (6) @(negedge sys_clk);
      check("mux pin", mux_pin, mux_sig);
    end
    mux_en = 1'b0;
    $display("test mux pin done");
    report_and_stop();
  end
endmodule : synth_loop_control_registers_tb_top
`default_nettype wire
